// ---- logic/pattern_pkg.sv ----
// Shared constants and types for the imaging test pattern generator.
package pattern_pkg;
  localparam logic [7:0] ADDR_SETUP = 8'h01;
  localparam logic [7:0] ADDR_RESERVED_A = 8'h36;
  localparam logic [7:0] ADDR_RESERVED_B = 8'h37;
  localparam logic [7:0] ADDR_PATTERN_CONTROL = 8'h38;
  localparam logic [7:0] ADDR_FIXED_CODE_HIGH = 8'h39;
  localparam logic [7:0] ADDR_FIXED_CODE_LOW = 8'h3a;
  localparam logic [7:0] ADDR_GRADATION_PITCH = 8'h3b;
  localparam logic [7:0] ADDR_GRADATION_STEP = 8'h3c;
  localparam logic [7:0] ADDR_COLOUR_LINE_DELAY = 8'h3d;
  localparam logic [7:0] ADDR_RESERVED_C = 8'h3e;
  localparam logic [7:0] ADDR_RESERVED_D = 8'h3f;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam int CLAMP_BIT = 4;
  localparam int PAT_ON_BIT = 7;
  localparam int KIND_HI = 6;
  localparam int KIND_LO = 5;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 3;
  localparam int LOW_CODE_HI = 7;
  localparam int LOW_CODE_LO = 6;
  localparam int DELAY_HI = 3;
  localparam int CODE_W = 10;
  localparam logic [9:0] CODE_FULL = 10'h3ff;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [3:0] GRID_MASK = 4'hf;
  localparam int HIST_DEPTH = 30;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    KIND_FIXED = 2'b00,
    KIND_MAIN_SCAN = 2'b01,
    KIND_SUB_SCAN = 2'b10,
    KIND_GRID = 2'b11
  } pattern_kind_e;
  typedef enum logic [1:0] {
    SEL_ALL = 2'b00,
    SEL_RED = 2'b01,
    SEL_GREEN = 2'b10,
    SEL_BLUE = 2'b11
  } colour_sel_e;
endpackage

// ---- logic/pattern_generator.sv ----
// Test pattern generator with register port, output FIFO and stream stage.
// Functional notes
// - Pattern enable clear passes converted pixels; set outputs the pattern.
// - Kind field: 00 fixed, 01 main-scan ramp, 10 sub-scan ramp, 11 grid.
// - Colour field: 00 all colours, 01 red, 10 green, 11 blue only.
// - With one colour chosen, the other colours carry code 1023.
// - Fixed code is high register bits 7:0 over low register bits 7:6.
// - Pitch value 1 to 255 sets how many units each ramp step spans; 0 also gives one unit.
// - Step value 0 to 255 is added to the ramp code at each step.
// - Delay field delays red to green and green to blue by 0-15 lines.
// - Setup register bit 4 turns the input over-voltage clamps on or off.

module stream_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic not_full_ff;
  logic not_empty_ff;
  logic push;
  logic pop;

  assign push = ce & in_valid & not_full_ff;
  assign pop = ce & not_empty_ff & out_ready;
  assign in_ready = not_full_ff;
  assign out_valid = not_empty_ff;
  assign out_data = mem_ff[rd_ff];

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Flags are registered so that ready and valid never ripple through logic.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      count_ff <= '0;
      not_full_ff <= 1'b1;
      not_empty_ff <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      count_ff <= nxt_count;
      not_full_ff <= (nxt_count != DEPTH[AW:0]);
      not_empty_ff <= (nxt_count != '0);
    end
  end
endmodule

module pattern_generator import pattern_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic input_clamp_on,
  input wire logic line_clamp_strobe,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [9:0] pix_red,
  input wire logic [9:0] pix_green,
  input wire logic [9:0] pix_blue,
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_red,
  output logic [9:0] out_green,
  output logic [9:0] out_blue
);
  logic [7:0] setup_ff;
  logic [7:0] reserved_a_ff;
  logic [7:0] reserved_b_ff;
  logic [7:0] pattern_control_ff;
  logic [7:0] fixed_code_high_ff;
  logic [7:0] fixed_code_low_ff;
  logic [7:0] gradation_pitch_ff;
  logic [7:0] gradation_step_ff;
  logic [7:0] colour_line_delay_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] line_sync_ff;
  logic line_evt;
  logic [7:0] pix_cnt_ff;
  logic [7:0] main_cnt_ff;
  logic [9:0] main_code_ff;
  logic [7:0] sub_cnt_ff;
  logic [9:0] sub_code_ff;
  logic [7:0] line_cnt_ff;
  logic [10:0] hist_ff [HIST_DEPTH];
  logic main_adv;
  logic sub_adv;
  logic pattern_output_on;
  pattern_kind_e pattern_kind;
  colour_sel_e pattern_colour_select;
  logic [9:0] fixed_pattern_code;
  logic [3:0] delay;
  logic [10:0] lag_green;
  logic [10:0] lag_blue;
  logic [9:0] pat_red;
  logic [9:0] pat_green;
  logic [9:0] pat_blue;
  logic [29:0] push_data;
  logic push;
  logic fifo_valid;
  logic fifo_take;
  logic [29:0] fifo_data;
  logic [29:0] out_data_ff;
  logic out_valid_ff;

  assign pattern_output_on = pattern_control_ff[PAT_ON_BIT];
  assign pattern_kind = pattern_kind_e'(pattern_control_ff[KIND_HI:KIND_LO]);
  assign pattern_colour_select =
    colour_sel_e'(pattern_control_ff[SEL_HI:SEL_LO]);
  assign fixed_pattern_code = {fixed_code_high_ff,
    fixed_code_low_ff[LOW_CODE_HI:LOW_CODE_LO]};
  assign delay = colour_line_delay_ff[DELAY_HI:0];
  assign reg_rdata = rdata_ff;
  assign input_clamp_on = setup_ff[CLAMP_BIT];
  assign out_valid = out_valid_ff;
  assign out_red = out_data_ff[29:20];
  assign out_green = out_data_ff[19:10];
  assign out_blue = out_data_ff[9:0];

  // Writes to reserved words A and B are stored and read back unchanged; C and D are not stored.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      setup_ff <= RESET_REG;
      reserved_a_ff <= RESET_REG;
      reserved_b_ff <= RESET_REG;
      pattern_control_ff <= RESET_REG;
      fixed_code_high_ff <= RESET_REG;
      fixed_code_low_ff <= RESET_REG;
      gradation_pitch_ff <= RESET_REG;
      gradation_step_ff <= RESET_REG;
      colour_line_delay_ff <= RESET_REG;
    end else if (ce && reg_write) begin
      if (reg_addr == ADDR_SETUP) begin
        setup_ff <= reg_wdata & (8'h01 << CLAMP_BIT);
      end else if (reg_addr == ADDR_RESERVED_A) begin
        reserved_a_ff <= reg_wdata;
      end else if (reg_addr == ADDR_RESERVED_B) begin
        reserved_b_ff <= reg_wdata;
      end else if (reg_addr == ADDR_PATTERN_CONTROL) begin
        pattern_control_ff <= {reg_wdata[7:3], 3'b000};
      end else if (reg_addr == ADDR_FIXED_CODE_HIGH) begin
        fixed_code_high_ff <= reg_wdata;
      end else if (reg_addr == ADDR_FIXED_CODE_LOW) begin
        fixed_code_low_ff <= {reg_wdata[7:6], 6'b000000};
      end else if (reg_addr == ADDR_GRADATION_PITCH) begin
        gradation_pitch_ff <= reg_wdata;
      end else if (reg_addr == ADDR_GRADATION_STEP) begin
        gradation_step_ff <= reg_wdata;
      end else if (reg_addr == ADDR_COLOUR_LINE_DELAY) begin
        colour_line_delay_ff <= {4'h0, reg_wdata[3:0]};
      end
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == ADDR_SETUP) begin
      nxt_rdata = setup_ff;
    end else if (reg_addr == ADDR_RESERVED_A) begin
      nxt_rdata = reserved_a_ff;
    end else if (reg_addr == ADDR_RESERVED_B) begin
      nxt_rdata = reserved_b_ff;
    end else if (reg_addr == ADDR_PATTERN_CONTROL) begin
      nxt_rdata = pattern_control_ff;
    end else if (reg_addr == ADDR_FIXED_CODE_HIGH) begin
      nxt_rdata = fixed_code_high_ff;
    end else if (reg_addr == ADDR_FIXED_CODE_LOW) begin
      nxt_rdata = fixed_code_low_ff;
    end else if (reg_addr == ADDR_GRADATION_PITCH) begin
      nxt_rdata = gradation_pitch_ff;
    end else if (reg_addr == ADDR_GRADATION_STEP) begin
      nxt_rdata = gradation_step_ff;
    end else if (reg_addr == ADDR_COLOUR_LINE_DELAY) begin
      nxt_rdata = colour_line_delay_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_ff <= 8'h00;
    end else if (ce && reg_read) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // The strobe comes from a pin, so only the second and third stages feed the edge.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      line_sync_ff <= 3'b000;
    end else if (ce) begin
      line_sync_ff <= {line_sync_ff[1:0], line_clamp_strobe};
    end
  end

  assign line_evt = ce & line_sync_ff[1] & ~line_sync_ff[2];
  assign push = ce & pix_valid & pix_ready & ~line_evt;
  assign main_adv = ({1'b0, main_cnt_ff} + 9'd1) >=
    {1'b0, gradation_pitch_ff};
  assign sub_adv = ({1'b0, sub_cnt_ff} + 9'd1) >=
    {1'b0, gradation_pitch_ff};

  // A pixel arriving with the line strobe is held off for one cycle.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pix_cnt_ff <= 8'h00;
      main_cnt_ff <= 8'h00;
      main_code_ff <= CODE_ZERO;
    end else if (line_evt) begin
      pix_cnt_ff <= 8'h00;
      main_cnt_ff <= 8'h00;
      main_code_ff <= CODE_ZERO;
    end else if (push) begin
      pix_cnt_ff <= pix_cnt_ff + 8'h01;
      if (main_adv) begin
        main_cnt_ff <= 8'h00;
        main_code_ff <= main_code_ff + {2'b00, gradation_step_ff};
      end else begin
        main_cnt_ff <= main_cnt_ff + 8'h01;
      end
    end
  end

  // Sub-scan state restarts whenever the pattern is switched off.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sub_cnt_ff <= 8'h00;
      sub_code_ff <= CODE_ZERO;
      line_cnt_ff <= 8'h00;
    end else if (ce && !pattern_output_on) begin
      sub_cnt_ff <= 8'h00;
      sub_code_ff <= CODE_ZERO;
      line_cnt_ff <= 8'h00;
    end else if (line_evt) begin
      line_cnt_ff <= line_cnt_ff + 8'h01;
      if (sub_adv) begin
        sub_cnt_ff <= 8'h00;
        sub_code_ff <= sub_code_ff + {2'b00, gradation_step_ff};
      end else begin
        sub_cnt_ff <= sub_cnt_ff + 8'h01;
      end
    end
  end

  // Line history gives green and blue their delayed view of the pattern.
  // The head entry is split off so no entry ever indexes below the array.
  for (genvar k = 0; k < HIST_DEPTH; k++) begin : g_hist
    logic [10:0] feed;
    if (k == 0) begin : g_head
      assign feed = {line_cnt_ff[3:0] == 4'h0, sub_code_ff};
    end else begin : g_tail
      assign feed = hist_ff[k-1];
    end
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        hist_ff[k] <= 11'h000;
      end else if (line_evt) begin
        hist_ff[k] <= feed;
      end
    end
  end

  function automatic logic [10:0] lag_of(input logic [4:0] n,
                                         input logic [10:0] now);
    lag_of = (n == 5'd0) ? now : hist_ff[n - 5'd1];
  endfunction

  function automatic logic [9:0] word_of(input logic [10:0] lag);
    case (pattern_kind)
      KIND_FIXED: word_of = fixed_pattern_code;
      KIND_MAIN_SCAN: word_of = main_code_ff;
      KIND_SUB_SCAN: word_of = lag[9:0];
      default: word_of = (lag[10] || (pix_cnt_ff[3:0] & GRID_MASK) == 4'h0)
        ? CODE_FULL : CODE_ZERO;
    endcase
  endfunction

  always_comb begin
    lag_green = lag_of({1'b0, delay},
      {line_cnt_ff[3:0] == 4'h0, sub_code_ff});
    lag_blue = lag_of({delay, 1'b0},
      {line_cnt_ff[3:0] == 4'h0, sub_code_ff});
    pat_red = word_of({line_cnt_ff[3:0] == 4'h0, sub_code_ff});
    pat_green = word_of(lag_green);
    pat_blue = word_of(lag_blue);
    if (pattern_colour_select != SEL_ALL &&
        pattern_colour_select != SEL_RED) begin
      pat_red = CODE_FULL;
    end
    if (pattern_colour_select != SEL_ALL &&
        pattern_colour_select != SEL_GREEN) begin
      pat_green = CODE_FULL;
    end
    if (pattern_colour_select != SEL_ALL &&
        pattern_colour_select != SEL_BLUE) begin
      pat_blue = CODE_FULL;
    end
    push_data = pattern_output_on ? {pat_red, pat_green, pat_blue}
      : {pix_red, pix_green, pix_blue};
  end

  stream_fifo #(.WIDTH(30), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(pix_valid & ~line_evt),
    .in_ready(pix_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  assign fifo_take = ~out_valid_ff | out_ready;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 30'h00000000;
    end else if (ce && fifo_take) begin
      out_valid_ff <= fifo_valid;
      if (fifo_valid) begin
        out_data_ff <= fifo_data;
      end
    end
  end

  property p_raw_pass;
    @(posedge clock) disable iff (!reset_n)
    push && !pattern_output_on |-> push_data == {pix_red, pix_green, pix_blue};
  endproperty
  a_raw_pass: assert property (p_raw_pass)
    else $error("raw pixel not passed through");

  property p_fixed;
    @(posedge clock) disable iff (!reset_n)
    push && pattern_output_on && pattern_kind == KIND_FIXED &&
    pattern_colour_select == SEL_ALL |->
    push_data[29:20] == fixed_pattern_code && push_data[9:0] ==
    fixed_pattern_code;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed code not on output");

  property p_red_only;
    @(posedge clock) disable iff (!reset_n)
    push && pattern_output_on && pattern_colour_select == SEL_RED |->
    push_data[19:0] == {CODE_FULL, CODE_FULL};
  endproperty
  a_red_only: assert property (p_red_only)
    else $error("unselected colours not at full code");

  property p_blue_sel;
    @(posedge clock) disable iff (!reset_n)
    push && pattern_output_on && pattern_colour_select == SEL_BLUE &&
    pattern_kind == KIND_MAIN_SCAN |->
    push_data[9:0] == main_code_ff && push_data[29:20] == CODE_FULL;
  endproperty
  a_blue_sel: assert property (p_blue_sel)
    else $error("blue selection wrong");

  property p_low_code;
    @(posedge clock) disable iff (!reset_n)
    ce && reg_write && reg_addr == ADDR_FIXED_CODE_LOW |=>
    fixed_pattern_code[1:0] == $past(reg_wdata[7:6]);
  endproperty
  a_low_code: assert property (p_low_code)
    else $error("fixed code low bits wrong");

  property p_sub_step;
    @(posedge clock) disable iff (!reset_n)
    line_evt && pattern_output_on && sub_adv |=>
    sub_code_ff == $past(sub_code_ff) + {2'b00, $past(gradation_step_ff)};
  endproperty
  a_sub_step: assert property (p_sub_step)
    else $error("sub scan step not added");

  property p_sub_hold;
    @(posedge clock) disable iff (!reset_n)
    line_evt && pattern_output_on && !sub_adv |=> $stable(sub_code_ff);
  endproperty
  a_sub_hold: assert property (p_sub_hold)
    else $error("ramp stepped before pitch ended");

  property p_green_delay;
    @(posedge clock) disable iff (!reset_n)
    push && pattern_output_on && pattern_kind == KIND_SUB_SCAN &&
    pattern_colour_select == SEL_ALL && delay != 4'h0 |->
    push_data[19:10] == hist_ff[delay - 4'h1][9:0];
  endproperty
  a_green_delay: assert property (p_green_delay)
    else $error("green not delayed");

  property p_clamp;
    @(posedge clock) disable iff (!reset_n)
    ce && reg_write && reg_addr == ADDR_SETUP |=>
    input_clamp_on == $past(reg_wdata[CLAMP_BIT]);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp enable wrong");

  property p_line_restart;
    @(posedge clock) disable iff (!reset_n)
    line_evt |=> pix_cnt_ff == 8'h00 && main_code_ff == CODE_ZERO;
  endproperty
  a_line_restart: assert property (p_line_restart)
    else $error("line start did not restart ramp");

  c_grid: cover property (@(posedge clock) disable iff (!reset_n)
    push && pattern_output_on && pattern_kind == KIND_GRID);
  c_main: cover property (@(posedge clock) disable iff (!reset_n)
    push && pattern_output_on && pattern_kind == KIND_MAIN_SCAN && main_adv);
  c_full: cover property (@(posedge clock) disable iff (!reset_n)
    !pix_ready);
endmodule

// ---- verification/pixel_sink.sv ----
// Output stream sink standing in for the far-side processing logic.
module pixel_sink (
  input wire logic clock,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [9:0] out_red,
  input wire logic [9:0] out_green,
  input wire logic [9:0] out_blue,
  input wire logic stall,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [29:0] got[$];
  logic phase = 1'b0;
  initial out_ready = 1'b0;
  // Ready moves only at the falling edge so each accept is a clean rising
  // edge; slow mode accepts every other cycle to exercise back-pressure.
  always @(negedge clock) begin
    phase <= ~phase;
    out_ready <= ~stall & (~slow | phase);
  end
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back({out_red, out_green, out_blue});
    end
  end
endmodule

// ---- verification/test_imaging_test_pattern_generator.sv ----
// Self-checking bench for the imaging test pattern generator.
module test_imaging_test_pattern_generator import pattern_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic input_clamp_on;
  logic line_clamp_strobe = 1'b0;
  logic pix_valid = 1'b0;
  logic pix_ready;
  logic [9:0] pix_red = 10'h000;
  logic [9:0] pix_green = 10'h000;
  logic [9:0] pix_blue = 10'h000;
  logic out_valid;
  logic out_ready;
  logic [9:0] out_red;
  logic [9:0] out_green;
  logic [9:0] out_blue;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  int bad_count = 0;
  int check_count = 0;

  always #50 clock = ~clock;

  pattern_generator #(.DEPTH(FIFO_DEPTH)) i_dut (
    .clock(clock), .reset_n(reset_n), .ce(ce),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .input_clamp_on(input_clamp_on), .line_clamp_strobe(line_clamp_strobe),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_red(pix_red),
    .pix_green(pix_green), .pix_blue(pix_blue), .out_valid(out_valid),
    .out_ready(out_ready), .out_red(out_red), .out_green(out_green),
    .out_blue(out_blue)
  );

  pixel_sink i_sink (
    .clock(clock), .out_valid(out_valid), .out_ready(out_ready),
    .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
    .stall(stall), .slow(slow)
  );

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [29:0] got, input logic [29:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    check(30'h0, 30'h1);
    conclude();
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = addr;
    @(negedge clock);
    reg_read = 1'b0;
    data = reg_rdata;
  endtask

  // Ready only changes at a rising edge, so its value at the falling edge
  // is the one the next rising edge samples.
  task automatic push(input logic [29:0] w);
    int n;
    n = 0;
    @(negedge clock);
    {pix_red, pix_green, pix_blue} = w;
    pix_valid = 1'b1;
    while (pix_ready !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 200) give_up();
    end
    @(negedge clock);
    pix_valid = 1'b0;
    {pix_red, pix_green, pix_blue} = ~w;
  endtask

  task automatic expect_word(input logic [29:0] exp);
    int n;
    n = 0;
    while (i_sink.got.size() == 0) begin
      @(negedge clock);
      n++;
      if (n > 200) give_up();
    end
    check(i_sink.got.pop_front(), exp);
  endtask

  // The strobe is held well past the synchroniser so the event lands
  // before any pixel is offered again.
  task automatic line_start();
    @(negedge clock);
    line_clamp_strobe = 1'b1;
    repeat (5) @(negedge clock);
    line_clamp_strobe = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  function automatic logic [9:0] sub_code(input int k);
    return (k < 0) ? 10'h000 : 10'((k / 2) * 100);
  endfunction

  task automatic s_registers();
    logic [7:0] d;
    logic [7:0] a [12] = '{8'h01, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a,
      8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40};
    logic [7:0] m [12] = '{8'h10, 8'h00, 8'h00, 8'hf8, 8'hff, 8'hc0,
      8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00};
    check({pix_ready, out_valid, input_clamp_on}, 30'h4);
    wr(8'h01, 8'h10);
    check(input_clamp_on, 1'b1);
    foreach (a[i]) begin
      rd(a[i], d);
      check(d, (i == 0) ? 8'h10 : 8'h00);
      // Reserved places are only read, never written.
      if (!(i inside {1, 2, 9, 10})) begin
        wr(a[i], 8'hff);
        rd(a[i], d);
        check(d, m[i]);
        wr(a[i], 8'h00);
      end
    end
    check(input_clamp_on, 1'b0);
  endtask

  task automatic s_fill();
    int n;
    n = 0;
    stall = 1'b1;
    @(negedge clock);
    while (pix_ready === 1'b1 && n < 40) begin
      {pix_red, pix_green, pix_blue} = {10'(n), 10'(n + 100), 10'(n + 200)};
      pix_valid = 1'b1;
      n++;
      @(negedge clock);
    end
    pix_valid = 1'b0;
    {pix_red, pix_green, pix_blue} = ~{pix_red, pix_green, pix_blue};
    check(30'(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2), 30'h1);
    slow = 1'b1;
    stall = 1'b0;
    for (int i = 0; i < n; i++) begin
      expect_word({10'(i), 10'(i + 100), 10'(i + 200)});
    end
    slow = 1'b0;
  endtask

  task automatic s_fixed();
    logic [29:0] e;
    wr(8'h39, 8'ha5);
    wr(8'h3a, 8'hc0);
    for (int s = 0; s < 4; s++) begin
      wr(8'h38, 8'h80 | 8'(s << 3));
      push(30'h15a5a5a5);
      e[29:20] = (s == 0 || s == 1) ? 10'h297 : 10'h3ff;
      e[19:10] = (s == 0 || s == 2) ? 10'h297 : 10'h3ff;
      e[9:0] = (s == 0 || s == 3) ? 10'h297 : 10'h3ff;
      expect_word(e);
    end
  endtask

  task automatic s_main_ramp();
    wr(8'h3b, 8'h02);
    wr(8'h3c, 8'hc8);
    wr(8'h38, 8'ha0);
    line_start();
    for (int i = 0; i < 14; i++) push(30'h0);
    for (int i = 0; i < 14; i++) begin
      expect_word({3{10'((i / 2) * 200)}});
    end
    line_start();
    push(30'h0);
    expect_word(30'h0);
  endtask

  task automatic s_sub_delay();
    wr(8'h38, 8'h00);
    wr(8'h3c, 8'h64);
    wr(8'h3d, 8'h01);
    // Strobes while disabled flush older ramp values out of the history.
    repeat (3) line_start();
    wr(8'h38, 8'hc0);
    for (int k = 0; k < 6; k++) begin
      push(30'h0);
      expect_word({sub_code(k), sub_code(k - 1), sub_code(k - 2)});
      line_start();
    end
  endtask

  task automatic s_grid();
    wr(8'h3d, 8'h00);
    wr(8'h38, 8'h00);
    wr(8'h38, 8'he0);
    push(30'h0);
    expect_word(30'h3fffffff);
    line_start();
    for (int i = 0; i < 18; i++) push(30'h0);
    for (int i = 0; i < 18; i++) begin
      expect_word({3{(i % 16 == 0) ? 10'h3ff : 10'h000}});
    end
    wr(8'h38, 8'h00);
  endtask

  // With the enable low nothing may be taken: no pixel, no register write.
  task automatic s_freeze();
    logic [7:0] d;
    @(negedge clock);
    ce = 1'b0;
    wr(8'h3b, 8'h55);
    push(30'h0abcdef);
    repeat (4) @(negedge clock);
    ce = 1'b1;
    repeat (4) @(negedge clock);
    check(30'(i_sink.got.size()), 30'h0);
    check({out_valid, pix_ready}, 30'h1);
    rd(8'h3b, d);
    check(d, 8'h02);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    s_registers();
    s_fill();
    s_fixed();
    s_main_ramp();
    s_sub_delay();
    s_grid();
    s_freeze();
    conclude();
  end
endmodule
